/* include/lfm_pkg.sv */
// constants, mode codes and command codes of the lf mode controller
// assumes a 100 mhz core clock; shared by core and link modules
package lfm_pkg;

   // ----------------------------------------------------------
   // operating modes
   // ----------------------------------------------------------
   typedef enum logic [1:0] {
      LFM_SLEEP = 2'b00,
      LFM_STANDBY = 2'b01,
      LFM_TRANSMIT = 2'b10,
      LFM_DIAGNOSE = 2'b11
   } lfm_mode_e;

   // ----------------------------------------------------------
   // timing
   // ----------------------------------------------------------
   localparam int unsigned CLK_PERIOD_PS = 10000;
   localparam int unsigned DETECT_TIME_NS = 2000;
   localparam int unsigned DETECT_CYC = (DETECT_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned TX_TIME_US = 100;
   localparam int unsigned TX_CYC = (TX_TIME_US * 1000 * 1000) / CLK_PERIOD_PS;
   localparam int unsigned DIAG_TIME_US = 20;
   localparam int unsigned DIAG_CYC = (DIAG_TIME_US * 1000 * 1000) / CLK_PERIOD_PS;
   localparam int unsigned TMR_W = 16;
   localparam int unsigned DET_W = 8;
   localparam logic [2:0] DET_EDGES_MIN = 3'h4;

   // ----------------------------------------------------------
   // command frame: cmd in [7:4], argument in [3:0]
   // ----------------------------------------------------------
   localparam int unsigned FRAME_BITS = 8;
   localparam int unsigned CMD_MSB = 7;
   localparam int unsigned CMD_LSB = 4;
   localparam logic [3:0] CMD_STANDBY = 4'h0;
   localparam logic [3:0] CMD_TRANSMIT = 4'h1;
   localparam logic [3:0] CMD_DIAGNOSE = 4'h2;
   localparam logic [3:0] CMD_SLEEP = 4'h3;
   localparam logic [3:0] CMD_CONFIG = 4'h4;

   // ----------------------------------------------------------
   // configuration and reply fields
   // ----------------------------------------------------------
   localparam int unsigned CFG_W = 3;
   localparam logic [2:0] CFG_RESET = 3'h0;
   localparam int unsigned CFG_ANT_A = 0;
   localparam int unsigned CFG_ANT_B = 1;
   localparam int unsigned CFG_DSEL = 2;
   localparam int unsigned PTR_W = 4;
   localparam logic [3:0] PTR_RESET = 4'h0;

endpackage

/* include/lfm_link_if.sv */
// carrier between core (reference clock) and spi link (serial clock)
// cmd_byte is stable whenever cmd_tgl may be sampled
interface lfm_link_if;
   logic [7:0] cmd_byte;
   logic cmd_tgl;
   logic [7:0] status;
   logic awake;

   modport core (
      input cmd_byte,
      input cmd_tgl,
      output status,
      output awake
   );
   modport link (
      output cmd_byte,
      output cmd_tgl,
      input status,
      input awake
   );
endinterface

/* hdl/lfm_link.sv */
// spi slave shift logic on the serial clock
// assumes mode 0 host, msb first, sclk idle outside frames
module lfm_link (
   input wire logic spi_sclk_i,
   input wire logic spi_cs_n_i,
   input wire logic spi_sdi_i,
   input wire logic rst_i,
   output logic spi_sdo_o,
   output logic spi_sdo_oe_o,
   lfm_link_if.link lk
);

   // ----------------------------------------------------------
   // state
   // ----------------------------------------------------------
   typedef struct packed {
      logic [6:0] shreg;
      logic [7:0] cmd;
      logic tgl;
      logic awake_s1;
      logic awake_s2;
      logic [7:0] stat_s1;
      logic [7:0] stat_s2;
   } lfm_link_s;

   lfm_link_s st_r;
   lfm_link_s st_nxt;
   logic [2:0] cnt_r;

   // frame bit counter, held clear while select is released between frames
   always_ff @(posedge spi_sclk_i or posedge spi_cs_n_i) begin
      if (spi_cs_n_i) begin
         cnt_r <= 3'h0;
      end else begin
         cnt_r <= cnt_r + 3'h1;
      end
   end

   always_comb begin
      st_nxt = st_r;
      st_nxt.awake_s1 = lk.awake;
      st_nxt.awake_s2 = st_r.awake_s1;
      st_nxt.stat_s1 = lk.status;
      st_nxt.stat_s2 = st_r.stat_s1;
      st_nxt.shreg = {st_r.shreg[5:0], spi_sdi_i};
      // whole byte: hand over by toggle
      if (cnt_r == 3'(lfm_pkg::FRAME_BITS - 1)) begin
         st_nxt.cmd = {st_r.shreg, spi_sdi_i};
         st_nxt.tgl = ~st_r.tgl;
      end
   end

   always_ff @(posedge spi_sclk_i or posedge rst_i) begin
      if (rst_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ----------------------------------------------------------
   // outputs
   // ----------------------------------------------------------
   assign lk.cmd_byte = st_r.cmd;
   assign lk.cmd_tgl = st_r.tgl;
   assign spi_sdo_o = st_r.stat_s2[3'h7 - cnt_r];
   // port released while asleep; core level masks a stale synced awake
   assign spi_sdo_oe_o = ~spi_cs_n_i & st_r.awake_s2 & lk.awake;

endmodule // lfm_link

/* hdl/lfm_top.sv */
// operating-mode controller of a two-channel lf initiator
// assumes carrier and immobilizer data come from logic on ref_clk_i
module lfm_top #(
   parameter int unsigned TX_CYCLES = lfm_pkg::TX_CYC
) (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic wake_pin_i,
   input wire logic direct_modulation_in_i,
   input wire logic resonator_return_pin_i,
   input wire logic lf_carrier_i,
   input wire logic immo_data_i,
   input wire logic spi_sclk_i,
   input wire logic spi_cs_n_i,
   input wire logic spi_sdi_i,
   output logic spi_sdo_o,
   output logic spi_sdo_oe_o,
   output logic antenna_drive_a_o,
   output logic antenna_drive_a_oe_o,
   output logic antenna_drive_b_o,
   output logic antenna_drive_b_oe_o,
   output logic data_out_o,
   output logic pll_enable_o,
   output logic lf_tx_enable_o,
   output logic diag_run_o,
   output logic spi_active_o,
   output logic clk_src_resonator_o
);

   // ----------------------------------------------------------
   // state
   // ----------------------------------------------------------
   typedef struct packed {
      lfm_pkg::lfm_mode_e mode;
      logic wake_s1;
      logic wake_s2;
      logic wake_s3;
      logic mod_s1;
      logic mod_s2;
      logic res_s1;
      logic res_s2;
      logic res_s3;
      logic tgl_s1;
      logic tgl_s2;
      logic tgl_s3;
      logic [lfm_pkg::CFG_W-1:0] cfg;
      logic err;
      logic [lfm_pkg::PTR_W-1:0] ptr;
      logic [lfm_pkg::TMR_W-1:0] tmr;
      logic [lfm_pkg::DET_W-1:0] det_cnt;
      logic [2:0] det_edges;
      logic det_done;
      logic clk_res;
      logic drv_a;
      logic drv_b;
      logic dout;
      logic [7:0] status;
   } lfm_core_s;

   lfm_core_s st_r;
   lfm_core_s st_nxt;
   logic wake_rise;
   logic cmd_new;
   logic [3:0] cmd;

   lfm_link_if lk ();

   lfm_link u_link (
      .spi_sclk_i(spi_sclk_i),
      .spi_cs_n_i(spi_cs_n_i),
      .spi_sdi_i(spi_sdi_i),
      .rst_i(rst_i),
      .spi_sdo_o(spi_sdo_o),
      .spi_sdo_oe_o(spi_sdo_oe_o),
      .lk(lk)
   );

   // antenna enable per mode and config bit
   function automatic logic ant_oe(lfm_pkg::lfm_mode_e m, logic en);
      case (m)
         lfm_pkg::LFM_TRANSMIT: ant_oe = en;
         lfm_pkg::LFM_DIAGNOSE: ant_oe = 1'b1;
         default: ant_oe = 1'b0;
      endcase
   endfunction

   assign wake_rise = st_r.wake_s2 & ~st_r.wake_s3;
   assign cmd_new = st_r.tgl_s2 ^ st_r.tgl_s3;
   assign cmd = lk.cmd_byte[lfm_pkg::CMD_MSB:lfm_pkg::CMD_LSB];

   // ----------------------------------------------------------
   // next state
   // ----------------------------------------------------------
   always_comb begin
      st_nxt = st_r;
      st_nxt.wake_s1 = wake_pin_i;
      st_nxt.wake_s2 = st_r.wake_s1;
      st_nxt.wake_s3 = st_r.wake_s2;
      st_nxt.mod_s1 = direct_modulation_in_i;
      st_nxt.mod_s2 = st_r.mod_s1;
      st_nxt.res_s1 = resonator_return_pin_i;
      st_nxt.res_s2 = st_r.res_s1;
      st_nxt.res_s3 = st_r.res_s2;
      st_nxt.tgl_s1 = lk.cmd_tgl;
      st_nxt.tgl_s2 = st_r.tgl_s1;
      st_nxt.tgl_s3 = st_r.tgl_s2;
      // clock source window after reset
      if (!st_r.det_done) begin
         st_nxt.det_cnt = st_r.det_cnt + lfm_pkg::DET_W'(1);
         if ((st_r.res_s2 ^ st_r.res_s3) && st_r.det_edges != 3'h7) begin
            st_nxt.det_edges = st_r.det_edges + 3'h1;
         end
         if (st_r.det_cnt == lfm_pkg::DET_W'(lfm_pkg::DETECT_CYC - 1)) begin
            st_nxt.det_done = 1'b1;
            st_nxt.clk_res = (st_r.det_edges >= lfm_pkg::DET_EDGES_MIN);
         end
      end
      case (st_r.mode)
         lfm_pkg::LFM_SLEEP: begin
            if (wake_rise) begin
               st_nxt.mode = lfm_pkg::LFM_STANDBY;
            end
         end
         lfm_pkg::LFM_TRANSMIT, lfm_pkg::LFM_DIAGNOSE: begin
            st_nxt.tmr = st_r.tmr - lfm_pkg::TMR_W'(1);
            if (st_r.tmr == '0) begin
               st_nxt.mode = lfm_pkg::LFM_STANDBY;
            end
         end
         default: begin
         end
      endcase
      // commands ignored while asleep
      if (cmd_new && st_r.mode != lfm_pkg::LFM_SLEEP) begin
         case (cmd)
            lfm_pkg::CMD_STANDBY: st_nxt.mode = lfm_pkg::LFM_STANDBY;
            lfm_pkg::CMD_SLEEP: st_nxt.mode = lfm_pkg::LFM_SLEEP;
            lfm_pkg::CMD_CONFIG: st_nxt.cfg = lk.cmd_byte[lfm_pkg::CFG_W-1:0];
            lfm_pkg::CMD_TRANSMIT: begin
               if (st_r.mode == lfm_pkg::LFM_STANDBY) begin
                  st_nxt.mode = lfm_pkg::LFM_TRANSMIT;
                  st_nxt.tmr = lfm_pkg::TMR_W'(TX_CYCLES - 1);
                  st_nxt.ptr = st_r.ptr + lfm_pkg::PTR_W'(1);
               end else begin
                  st_nxt.err = 1'b1;
               end
            end
            lfm_pkg::CMD_DIAGNOSE: begin
               if (st_r.mode == lfm_pkg::LFM_STANDBY) begin
                  st_nxt.mode = lfm_pkg::LFM_DIAGNOSE;
                  st_nxt.tmr = lfm_pkg::TMR_W'(lfm_pkg::DIAG_CYC - 1);
               end else begin
                  st_nxt.err = 1'b1;
               end
            end
            default: st_nxt.err = 1'b1;
         endcase
      end
      // defaults restored on the way into sleep
      if (st_nxt.mode == lfm_pkg::LFM_SLEEP) begin
         st_nxt.cfg = lfm_pkg::CFG_RESET;
         st_nxt.err = 1'b0;
         st_nxt.ptr = lfm_pkg::PTR_RESET;
         st_nxt.tmr = '0;
      end
      // antenna data: carrier gated by modulation level in transmit, ungated in diagnose
      st_nxt.drv_a = 1'b0;
      st_nxt.drv_b = 1'b0;
      st_nxt.dout = 1'b0;
      if (st_r.mode == lfm_pkg::LFM_TRANSMIT) begin
         st_nxt.drv_a = lf_carrier_i & st_r.mod_s2;
         st_nxt.drv_b = ~lf_carrier_i & st_r.mod_s2;
         st_nxt.dout = st_r.cfg[lfm_pkg::CFG_DSEL] ? immo_data_i : st_r.mod_s2;
      end else if (st_r.mode == lfm_pkg::LFM_DIAGNOSE) begin
         st_nxt.drv_a = lf_carrier_i;
         st_nxt.drv_b = ~lf_carrier_i;
      end
      st_nxt.status = {st_r.mode, st_r.clk_res, st_r.err, st_r.ptr};
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         st_r <= '0;
      end else if (ce_i) begin
         st_r <= st_nxt;
      end
   end

   // ----------------------------------------------------------
   // outputs
   // ----------------------------------------------------------
   assign lk.status = st_r.status;
   assign lk.awake = (st_r.mode != lfm_pkg::LFM_SLEEP);
   assign antenna_drive_a_o = st_r.drv_a;
   assign antenna_drive_b_o = st_r.drv_b;
   assign antenna_drive_a_oe_o = ant_oe(st_r.mode, st_r.cfg[lfm_pkg::CFG_ANT_A]);
   assign antenna_drive_b_oe_o = ant_oe(st_r.mode, st_r.cfg[lfm_pkg::CFG_ANT_B]);
   assign data_out_o = st_r.dout;
   assign pll_enable_o = (st_r.mode != lfm_pkg::LFM_SLEEP) & st_r.det_done;
   assign lf_tx_enable_o = (st_r.mode == lfm_pkg::LFM_TRANSMIT);
   assign diag_run_o = (st_r.mode == lfm_pkg::LFM_DIAGNOSE);
   assign spi_active_o = (st_r.mode != lfm_pkg::LFM_SLEEP);
   assign clk_src_resonator_o = st_r.clk_res;

   // ----------------------------------------------------------
   // assertions
   // ----------------------------------------------------------
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (rst_i);

   sequence s_enter_sleep;
      (st_r.mode != lfm_pkg::LFM_SLEEP) ##1 (st_r.mode == lfm_pkg::LFM_SLEEP);
   endsequence
   sequence s_tx_cmd;
      ce_i && cmd_new && cmd == lfm_pkg::CMD_TRANSMIT
         && st_r.mode == lfm_pkg::LFM_STANDBY;
   endsequence

   property p_sleep_clear;
      s_enter_sleep |-> st_r.cfg == lfm_pkg::CFG_RESET && !st_r.err
         && st_r.ptr == lfm_pkg::PTR_RESET;
   endproperty
   a_sleep_clear: assert property (p_sleep_clear) else $error("sleep entry kept state");

   property p_sleep_off;
      st_r.mode == lfm_pkg::LFM_SLEEP |-> !antenna_drive_a_oe_o && !antenna_drive_b_oe_o
         && !pll_enable_o && !spi_active_o;
   endproperty
   a_sleep_off: assert property (p_sleep_off) else $error("active output in sleep");

   property p_wake_only;
      st_r.mode == lfm_pkg::LFM_SLEEP && !wake_rise |=> st_r.mode == lfm_pkg::LFM_SLEEP;
   endproperty
   a_wake_only: assert property (p_wake_only) else $error("left sleep without wake");

   property p_wake_go;
      st_r.mode == lfm_pkg::LFM_SLEEP && wake_rise && ce_i
         |=> st_r.mode == lfm_pkg::LFM_STANDBY;
   endproperty
   a_wake_go: assert property (p_wake_go) else $error("wake edge missed");

   property p_standby_quiet;
      st_r.mode == lfm_pkg::LFM_STANDBY ##1 st_r.mode == lfm_pkg::LFM_STANDBY
         |-> !antenna_drive_a_oe_o && !antenna_drive_b_oe_o && !data_out_o
         && !lf_tx_enable_o;
   endproperty
   a_standby_quiet: assert property (p_standby_quiet) else $error("standby not quiet");

   property p_tx_start;
      s_tx_cmd |=> st_r.mode == lfm_pkg::LFM_TRANSMIT ##0 lf_tx_enable_o;
   endproperty
   a_tx_start: assert property (p_tx_start) else $error("transmit command lost");

   property p_tx_ant;
      st_r.mode == lfm_pkg::LFM_TRANSMIT |-> antenna_drive_a_oe_o
         == st_r.cfg[lfm_pkg::CFG_ANT_A] && antenna_drive_b_oe_o == st_r.cfg[lfm_pkg::CFG_ANT_B];
   endproperty
   a_tx_ant: assert property (p_tx_ant) else $error("antenna enable not per config");

   property p_diag;
      st_r.mode == lfm_pkg::LFM_DIAGNOSE ##1 st_r.mode == lfm_pkg::LFM_DIAGNOSE
         |-> antenna_drive_a_oe_o && antenna_drive_b_oe_o && !data_out_o;
   endproperty
   a_diag: assert property (p_diag) else $error("diagnose outputs wrong");

   property p_mod;
      st_r.mode == lfm_pkg::LFM_TRANSMIT && ce_i
         |=> antenna_drive_a_o == ($past(lf_carrier_i) & $past(st_r.mod_s2));
   endproperty
   a_mod: assert property (p_mod) else $error("carrier not gated by modulation");

   property p_dout;
      st_r.mode == lfm_pkg::LFM_TRANSMIT && ce_i |=> data_out_o ==
         ($past(st_r.cfg[lfm_pkg::CFG_DSEL]) ? $past(immo_data_i) : $past(st_r.mod_s2));
   endproperty
   a_dout: assert property (p_dout) else $error("data pin source wrong");

   property p_detect;
      $fell(rst_i) ##0 ce_i [*8] |-> ##[1:400] st_r.det_done;
   endproperty
   a_detect: assert property (p_detect) else $error("clock source not decided");

   property p_finish;
      st_r.mode == lfm_pkg::LFM_TRANSMIT && st_r.tmr == '0 && ce_i && !cmd_new
         |=> st_r.mode == lfm_pkg::LFM_STANDBY;
   endproperty
   a_finish: assert property (p_finish) else $error("no return to standby");

endmodule // lfm_top

/* sim/lfm_host_model.sv */
// spi host model facing the link side of the lf mode controller
// assumes mode 0 frames, msb first, 15 ns serial clock, idle outside frames
module lfm_host_model (
   output logic spi_sclk_o,
   output logic spi_cs_n_o,
   output logic spi_sdi_o,
   input wire logic spi_sdo_i,
   input wire logic spi_sdo_oe_i
);
   timeunit 1ns;
   timeprecision 100ps;

   initial begin
      spi_sclk_o = 1'b0;
      spi_cs_n_o = 1'b1;
      spi_sdi_o = 1'b0;
   end

   // ---------------------------------------------
   // one whole command byte, slow stretches sclk
   // ---------------------------------------------
   task automatic xfer(input logic [7:0] tx, input int slow, output logic [7:0] rx,
         output logic oe_seen);
      oe_seen = 1'b0;
      rx = 8'h00;
      spi_cs_n_o = 1'b0;
      for (int i = 7; i >= 0; i--) begin
         spi_sdi_o = tx[i];
         #(7.5 * (slow + 1));
         // sampled ahead of the edge that shifts the reply
         rx[i] = spi_sdo_i;
         oe_seen = oe_seen | spi_sdo_oe_i;
         spi_sclk_o = 1'b1;
         #(7.5 * (slow + 1));
         spi_sclk_o = 1'b0;
      end
      spi_cs_n_o = 1'b1;
      spi_sdi_o = ~tx[0];
   endtask
endmodule // lfm_host_model

/* sim/lfm_top_tb.sv */
// self-checking bench of the lf mode controller
// assumes lfm_pkg, lfm_link_if, the design and the host model compile first
module lfm_top_tb;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int unsigned TXC = 50;
   logic ref_clk_i, rst_i, ce, wake, mod, res_pin, carrier, immo;
   logic sclk, cs_n, sdi, sdo, sdo_oe, ant_a, a_oe, ant_b, b_oe;
   logic dout, pll, tx_en, diag, spi_act, clk_res;
   logic [7:0] rx;
   logic oe_seen;
   int n_mismatch = 0;
   int n_tests = 0;
   int cyc = 0;

   lfm_top #(.TX_CYCLES(TXC)) dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .ce_i(ce),
      .wake_pin_i(wake), .direct_modulation_in_i(mod), .resonator_return_pin_i(res_pin),
      .lf_carrier_i(carrier), .immo_data_i(immo), .spi_sclk_i(sclk), .spi_cs_n_i(cs_n),
      .spi_sdi_i(sdi), .spi_sdo_o(sdo), .spi_sdo_oe_o(sdo_oe), .antenna_drive_a_o(ant_a),
      .antenna_drive_a_oe_o(a_oe), .antenna_drive_b_o(ant_b), .antenna_drive_b_oe_o(b_oe),
      .data_out_o(dout), .pll_enable_o(pll), .lf_tx_enable_o(tx_en), .diag_run_o(diag),
      .spi_active_o(spi_act), .clk_src_resonator_o(clk_res));

   lfm_host_model host (.spi_sclk_o(sclk), .spi_cs_n_o(cs_n), .spi_sdi_o(sdi),
      .spi_sdo_i(sdo), .spi_sdo_oe_i(sdo_oe));

   initial begin
      ref_clk_i = 1'b0;
      forever #5 ref_clk_i = ~ref_clk_i;
   end

   always @(posedge ref_clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_mismatch++;
         give_verdict();
      end
   end

   // ---------------------------------------------
   // shared tasks
   // ---------------------------------------------
   task automatic give_verdict();
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic exp, input logic got);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %b seen %b", what, exp, got);
      end
   endtask

   task automatic step(input int n);
      repeat (n) @(posedge ref_clk_i);
      #1;
   endtask

   task automatic send(input logic [3:0] cmd, input logic [3:0] arg, input logic awake,
         input int slow);
      step(9);
      host.xfer({cmd, arg}, slow, rx, oe_seen);
      chk("sdo_oe", awake, oe_seen);
   endtask

   task automatic wake_up();
      wake = 1'b1;
      for (int i = 0; i < 8 && spi_act !== 1'b1; i++)
         step(1);
      chk("spi_active", 1'b1, spi_act);
      chk("pll", 1'b1, pll);
      chk("tx_en", 1'b0, tx_en);
      chk("oe_a", 1'b0, a_oe);
      chk("oe_b", 1'b0, b_oe);
      chk("dout", 1'b0, dout);
      wake = 1'b0;
   endtask

   // ---------------------------------------------
   // scenarios
   // ---------------------------------------------
   task automatic settle(input logic res);
      rst_i = 1'b1;
      step(2);
      rst_i = 1'b0;
      for (int i = 0; i < 220; i++) begin
         step(1);
         if (res && i % 4 == 0)
            res_pin = ~res_pin;
      end
      chk("clk_src", res, clk_res);
      chk("spi_active", 1'b0, spi_act);
      chk("pll", 1'b0, pll);
      chk("oe_a", 1'b0, a_oe);
      chk("oe_b", 1'b0, b_oe);
      send(lfm_pkg::CMD_STANDBY, 4'h0, 1'b0, 0);
      step(8);
      chk("spi_active", 1'b0, spi_act);
   endtask

   task automatic t_transmit(input logic [2:0] cfg);
      logic [1:0] cm;
      send(lfm_pkg::CMD_CONFIG, {1'b0, cfg}, 1'b1, 0);
      send(lfm_pkg::CMD_TRANSMIT, 4'h0, 1'b1, 0);
      // reply carries mode seen during the previous (standby) frame
      chk("reply_mode_hi", 1'b0, rx[7]);
      chk("reply_mode_lo", 1'b1, rx[6]);
      for (int i = 0; i < 8 && tx_en !== 1'b1; i++)
         step(1);
      chk("tx_en", 1'b1, tx_en);
      chk("oe_a", cfg[0], a_oe);
      chk("oe_b", cfg[1], b_oe);
      for (int k = 1; k < 4; k++) begin
         cm = k[1:0];
         carrier = cm[1];
         mod = cm[0];
         immo = ~cm[0];
         step(4);
         if (cfg[0])
            chk("ant_a", cm[1] & cm[0], ant_a);
         if (cfg[1])
            chk("ant_b", ~cm[1] & cm[0], ant_b);
         chk("dout", cfg[2] ? ~cm[0] : cm[0], dout);
      end
      send(lfm_pkg::CMD_DIAGNOSE, 4'h0, 1'b1, 0);
      step(5);
      chk("diag", 1'b0, diag);
      chk("tx_en", 1'b1, tx_en);
      for (int i = 0; i < 40 && tx_en !== 1'b0; i++)
         step(1);
      chk("tx_en", 1'b0, tx_en);
      chk("spi_active", 1'b1, spi_act);
      // registered outputs follow the mode one cycle later
      step(1);
      chk("oe_a", 1'b0, a_oe);
      chk("oe_b", 1'b0, b_oe);
      chk("dout", 1'b0, dout);
   endtask

   task automatic t_diag();
      carrier = 1'b1;
      mod = 1'b0;
      send(lfm_pkg::CMD_DIAGNOSE, 4'h0, 1'b1, 2);
      for (int i = 0; i < 8 && diag !== 1'b1; i++)
         step(1);
      chk("diag", 1'b1, diag);
      chk("tx_en", 1'b0, tx_en);
      chk("oe_a", 1'b1, a_oe);
      chk("oe_b", 1'b1, b_oe);
      step(2);
      chk("ant_a", 1'b1, ant_a);
      chk("ant_b", 1'b0, ant_b);
      chk("dout", 1'b0, dout);
      for (int i = 0; i < 2100 && diag !== 1'b0; i++)
         step(1);
      chk("diag", 1'b0, diag);
      chk("spi_active", 1'b1, spi_act);
   endtask

   task automatic t_sleep();
      send(lfm_pkg::CMD_SLEEP, 4'h0, 1'b1, 0);
      for (int i = 0; i < 8 && spi_act !== 1'b0; i++)
         step(1);
      chk("spi_active", 1'b0, spi_act);
      chk("pll", 1'b0, pll);
      chk("oe_b", 1'b0, b_oe);
      // frame while asleep right after an awake frame: port stays released
      send(lfm_pkg::CMD_STANDBY, 4'h0, 1'b0, 0);
      step(8);
      chk("spi_active", 1'b0, spi_act);
      // wake edge while frozen is not seen
      ce = 1'b0;
      wake = 1'b1;
      step(6);
      chk("spi_active", 1'b0, spi_act);
      wake = 1'b0;
      step(2);
      ce = 1'b1;
      step(4);
      chk("spi_active", 1'b0, spi_act);
      wake_up();
      send(lfm_pkg::CMD_TRANSMIT, 4'h0, 1'b1, 0);
      for (int i = 0; i < 8 && tx_en !== 1'b1; i++)
         step(1);
      chk("tx_en", 1'b1, tx_en);
      chk("oe_a", 1'b0, a_oe);
      chk("oe_b", 1'b0, b_oe);
      step(60);
   endtask

   initial begin
      rst_i = 1'b1;
      ce = 1'b1;
      wake = 1'b0;
      mod = 1'b0;
      res_pin = 1'b0;
      carrier = 1'b0;
      immo = 1'b0;
      settle(1'b0);
      wake_up();
      t_transmit(3'b101);
      t_transmit(3'b010);
      t_diag();
      t_sleep();
      settle(1'b1);
      give_verdict();
   end
endmodule // lfm_top_tb
